// [rtl/avs_pkg.sv]
// constants for the volume and soft-step control block
// assumes a single 250 MHz clock and page-2 register addresses on the port
package avs_pkg;

    localparam int AVS_ADDR_W = 4;
    localparam int AVS_DATA_W = 16;
    localparam int AVS_CODE_W = 7;
    localparam int AVS_SAMPLE_W = 20;

    typedef logic [AVS_CODE_W-1:0] avs_code_t;
    typedef logic [AVS_ADDR_W-1:0] avs_addr_t;
    typedef logic [AVS_DATA_W-1:0] avs_word_t;

    // register addresses within the audio page
    localparam avs_addr_t AVS_ADDR_ADC = 4'h1;
    localparam avs_addr_t AVS_ADDR_DAC = 4'h2;
    localparam avs_addr_t AVS_ADDR_BYP = 4'h3;

    // field positions, identical for all three registers
    localparam int AVS_LEFT_MUTE_BIT = 15;
    localparam int AVS_LEFT_CODE_HI = 14;
    localparam int AVS_LEFT_CODE_LO = 8;
    localparam int AVS_RIGHT_MUTE_BIT = 7;
    localparam int AVS_RIGHT_CODE_HI = 6;
    localparam int AVS_RIGHT_CODE_LO = 0;

    // reset values of the fields
    localparam logic AVS_MUTE_RESET = 1'h1;
    localparam avs_code_t AVS_ADC_CODE_RESET = 7'h57;
    localparam avs_code_t AVS_DAC_CODE_RESET = 7'h7F;
    localparam avs_code_t AVS_BYP_CODE_RESET = 7'h67;

    // lowest audible level and the mute threshold per path
    localparam avs_code_t AVS_ADC_FLOOR = 7'h07;
    localparam avs_code_t AVS_ADC_THRESH = 7'h07;
    localparam avs_code_t AVS_DAC_FLOOR = 7'h00;
    localparam avs_code_t AVS_DAC_THRESH = 7'h00;
    localparam avs_code_t AVS_BYP_FLOOR = 7'h20;
    localparam avs_code_t AVS_BYP_THRESH = 7'h20;

    // soft-step interval
    localparam int AVS_CLK_PERIOD_PS = 4000;
    localparam int AVS_STEP_TIME_US = 20;
    localparam int AVS_STEP_CYCLES =
        (AVS_STEP_TIME_US * 1000000) / AVS_CLK_PERIOD_PS;
    localparam int AVS_STEP_CNT_W = 16;

endpackage

// [rtl/avs_ramp.sv]
// one soft-stepped gain channel: applied code walks toward its target
// assumes step_en is a one-cycle pulse from the step divider
`timescale 1ns/1ps
`default_nettype none

module avs_ramp
    import avs_pkg::*;
#(
    parameter avs_code_t FLOOR = 7'h00,
    parameter avs_code_t THRESH = 7'h00
) (
    input wire logic ref_clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire logic step_en, // one soft-step update allowed
    input wire logic mute_bit, // stored mute bit
    input wire avs_code_t gain_code, // stored gain code
    input wire avs_code_t reset_code, // applied code after reset
    output avs_code_t applied_code, // gain code now applied
    output logic muted, // path is hard muted
    output logic busy // ramp still moving
);

    avs_code_t applied_r;
    avs_code_t applied_nxt;
    avs_code_t target;
    logic muted_r;
    logic muted_nxt;
    logic want_mute;
    logic at_floor;

    // a code under the threshold acts like the mute bit
    assign want_mute = mute_bit | (gain_code < THRESH);
    // muted: head for the floor, but the stored code is never touched
    assign target = want_mute ? FLOOR : gain_code;
    assign at_floor = (applied_r == FLOOR);

    // one unit per update, never a jump
    assign applied_nxt = !step_en ? applied_r :
        (applied_r < target) ? applied_r + 7'h01 :
        (applied_r > target) ? applied_r - 7'h01 :
        applied_r;

    // mute only after reaching the floor; unmute first, then ramp up
    assign muted_nxt = want_mute ? (muted_r | at_floor) : 1'b0;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            applied_r <= reset_code;
            muted_r <= 1'b1;
        end else begin
            applied_r <= applied_nxt;
            muted_r <= muted_nxt;
        end
    end

    assign applied_code = applied_r;
    assign muted = muted_r;
    assign busy = (applied_r != target) | (want_mute & ~muted_r);

endmodule

`default_nettype wire

// [rtl/avs_top.sv]
// volume, mute and soft-step control for the adc, dac and bypass paths
// assumes the serial control port has already decoded page-2 accesses
// into single-cycle write and read strobes synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none

// How it works
// - adc gain code linear in 0.5 dB: 7Fh +20, 57h 0, 07h -40 dB
// - adc code below 07h mutes the channel like its mute bit
// - adc mute ramps gain to lowest then mutes; unmute reverses
// - adc hard mute ties the input to the common-mode reference
// - adc mute keeps stored code; unmute returns to it
// - every adc gain change is soft-stepped, never a jump
// - adc word: 15 left mute, 14-8 left code, 7 right mute, 6-0 right
// - adc reset: both mutes 1, both codes 1010111
// - dac gain 0.5 dB per code: 7Fh 0 dB, 00h -63.5 dB
// - dac mute ramps to lowest then sends zero samples; clear reverses
// - dac mute keeps stored code; unmute returns to it
// - dac word: 15 left mute, 14-8 left code, 7 right mute, 6-0 right
// - dac reset: both mutes 1, both codes 1111111
// - right dac mute acts on right channel only, restoring its code
// - bypass gain 0.5 dB per code: 7Fh +12, 67h 0, 20h -35.5 dB
// - bypass code below 20h mutes that bypass path
// - bypass mute ramps to lowest then cuts the path; clear reverses
// - bypass word: 15 left mute, 14-8 left code; reset 1 and 1100111
// - right bypass half mirrors left; reset mute 1, code 1100111
// - ramp updates every 20 us, or 40 us at half rate
// - read-only done flag is 0 while any ramp runs, else 1
module avs_top
    import avs_pkg::*;
#(
    parameter int STEP_CYCLES = AVS_STEP_CYCLES
) (
    input wire logic ref_clk, // 250 MHz clock
    input wire logic reset, // synchronous, active high
    input wire logic reg_wr_en, // register write strobe
    input wire logic reg_rd_en, // register read strobe
    input wire avs_addr_t reg_addr, // register address in the page
    input wire avs_word_t reg_wdata, // write data
    output avs_word_t reg_rdata, // read data, one cycle after strobe
    output logic reg_rd_valid, // read data valid pulse
    input wire logic softstep_rate_select, // 1 selects half step rate
    output logic softstep_done_flag, // 1 when all ramps are finished
    output avs_code_t adc_left_applied_gain, // left adc stage gain code
    output avs_code_t adc_right_applied_gain, // right adc stage gain code
    output logic adc_left_tie_common_mode, // left input to reference
    output logic adc_right_tie_common_mode, // right input to reference
    output avs_code_t dac_left_applied_gain, // left dac digital gain
    output avs_code_t dac_right_applied_gain, // right dac digital gain
    input wire logic dac_sample_valid, // new sample pair present
    input wire logic [AVS_SAMPLE_W-1:0] dac_left_sample_in, // left sample
    input wire logic [AVS_SAMPLE_W-1:0] dac_right_sample_in, // right sample
    output logic [AVS_SAMPLE_W-1:0] dac_left_sample_out, // to left filter
    output logic [AVS_SAMPLE_W-1:0] dac_right_sample_out, // to right filter
    output logic dac_sample_out_valid, // output sample pair valid
    output avs_code_t bypass_left_applied_gain, // left bypass stage gain
    output avs_code_t bypass_right_applied_gain, // right bypass stage gain
    output logic bypass_left_path_mute, // left line-in to outputs cut
    output logic bypass_right_path_mute // right line-in to outputs cut
);

    // field helpers shared by every register
    function automatic avs_code_t left_code(input avs_word_t w);
        left_code = w[AVS_LEFT_CODE_HI:AVS_LEFT_CODE_LO];
    endfunction

    function automatic avs_code_t right_code(input avs_word_t w);
        right_code = w[AVS_RIGHT_CODE_HI:AVS_RIGHT_CODE_LO];
    endfunction

    function automatic avs_word_t pack_word(input logic lm,
            input avs_code_t lc, input logic rm, input avs_code_t rc);
        pack_word = {lm, lc, rm, rc};
    endfunction

    localparam avs_word_t ADC_RESET = pack_word(AVS_MUTE_RESET,
        AVS_ADC_CODE_RESET, AVS_MUTE_RESET, AVS_ADC_CODE_RESET);
    localparam avs_word_t DAC_RESET = pack_word(AVS_MUTE_RESET,
        AVS_DAC_CODE_RESET, AVS_MUTE_RESET, AVS_DAC_CODE_RESET);
    localparam avs_word_t BYP_RESET = pack_word(AVS_MUTE_RESET,
        AVS_BYP_CODE_RESET, AVS_MUTE_RESET, AVS_BYP_CODE_RESET);
    localparam logic [AVS_STEP_CNT_W-1:0] STEP_LAST =
        AVS_STEP_CNT_W'(STEP_CYCLES - 1);

    // stored registers
    avs_word_t adc_gain_r;
    avs_word_t dac_gain_r;
    avs_word_t byp_gain_r;
    avs_word_t reg_rdata_r;
    avs_word_t rd_mux;
    logic reg_rd_valid_r;

    // address decode
    logic hit_adc;
    logic hit_dac;
    logic hit_byp;
    logic wr_adc;
    logic wr_dac;
    logic wr_byp;

    assign hit_adc = (reg_addr == AVS_ADDR_ADC);
    assign hit_dac = (reg_addr == AVS_ADDR_DAC);
    assign hit_byp = (reg_addr == AVS_ADDR_BYP);
    assign wr_adc = reg_wr_en & hit_adc;
    assign wr_dac = reg_wr_en & hit_dac;
    assign wr_byp = reg_wr_en & hit_byp;

    // field views of the stored words
    logic adc_left_mute;
    logic adc_right_mute;
    avs_code_t adc_left_gain_code;
    avs_code_t adc_right_gain_code;
    logic dac_left_mute;
    logic dac_right_mute;
    avs_code_t dac_left_gain_code;
    avs_code_t dac_right_gain_code;
    logic bypass_left_mute;
    logic bypass_right_mute;
    avs_code_t bypass_left_gain_code;
    avs_code_t bypass_right_gain_code;

    assign adc_left_mute = adc_gain_r[AVS_LEFT_MUTE_BIT];
    assign adc_right_mute = adc_gain_r[AVS_RIGHT_MUTE_BIT];
    assign adc_left_gain_code = left_code(adc_gain_r);
    assign adc_right_gain_code = right_code(adc_gain_r);
    assign dac_left_mute = dac_gain_r[AVS_LEFT_MUTE_BIT];
    assign dac_right_mute = dac_gain_r[AVS_RIGHT_MUTE_BIT];
    assign dac_left_gain_code = left_code(dac_gain_r);
    assign dac_right_gain_code = right_code(dac_gain_r);
    assign bypass_left_mute = byp_gain_r[AVS_LEFT_MUTE_BIT];
    assign bypass_right_mute = byp_gain_r[AVS_RIGHT_MUTE_BIT];
    assign bypass_left_gain_code = left_code(byp_gain_r);
    assign bypass_right_gain_code = right_code(byp_gain_r);

    // the whole word is stored as written; all bits are live fields
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            adc_gain_r <= ADC_RESET;
            dac_gain_r <= DAC_RESET;
            byp_gain_r <= BYP_RESET;
        end else begin
            if (wr_adc) begin
                adc_gain_r <= reg_wdata;
            end
            if (wr_dac) begin
                dac_gain_r <= reg_wdata;
            end
            if (wr_byp) begin
                byp_gain_r <= reg_wdata;
            end
        end
    end

    // reads return the stored words; unmapped addresses read zero
    assign rd_mux = hit_adc ? adc_gain_r :
        hit_dac ? dac_gain_r :
        hit_byp ? byp_gain_r :
        '0;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata_r <= '0;
            reg_rd_valid_r <= 1'b0;
        end else begin
            reg_rd_valid_r <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata_r <= rd_mux;
            end
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign reg_rd_valid = reg_rd_valid_r;

    // step divider: base tick every 20 us, every other tick at half rate
    logic [AVS_STEP_CNT_W-1:0] step_cnt_r;
    logic [AVS_STEP_CNT_W-1:0] step_cnt_nxt;
    logic base_tick;
    logic half_phase_r;
    logic step_en;

    assign base_tick = (step_cnt_r == STEP_LAST);
    assign step_cnt_nxt = base_tick ? '0 : step_cnt_r + 1'b1;
    assign step_en = base_tick &
        (~softstep_rate_select | half_phase_r);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            step_cnt_r <= '0;
            half_phase_r <= 1'b0;
        end else begin
            step_cnt_r <= step_cnt_nxt;
            if (base_tick) begin
                half_phase_r <= ~half_phase_r;
            end
        end
    end

    // six independent ramps; codes map linearly so the applied code is
    // handed straight to each gain stage
    logic adc_left_muted;
    logic adc_right_muted;
    logic dac_left_muted;
    logic dac_right_muted;
    logic byp_left_muted;
    logic byp_right_muted;
    logic [5:0] ramp_busy;

    avs_ramp #(.FLOOR(AVS_ADC_FLOOR), .THRESH(AVS_ADC_THRESH)) u_adc_left (
        .ref_clk(ref_clk),
        .reset(reset),
        .step_en(step_en),
        .mute_bit(adc_left_mute),
        .gain_code(adc_left_gain_code),
        .reset_code(AVS_ADC_FLOOR),
        .applied_code(adc_left_applied_gain),
        .muted(adc_left_muted),
        .busy(ramp_busy[0])
    );

    avs_ramp #(.FLOOR(AVS_ADC_FLOOR), .THRESH(AVS_ADC_THRESH)) u_adc_right (
        .ref_clk(ref_clk),
        .reset(reset),
        .step_en(step_en),
        .mute_bit(adc_right_mute),
        .gain_code(adc_right_gain_code),
        .reset_code(AVS_ADC_FLOOR),
        .applied_code(adc_right_applied_gain),
        .muted(adc_right_muted),
        .busy(ramp_busy[1])
    );

    avs_ramp #(.FLOOR(AVS_DAC_FLOOR), .THRESH(AVS_DAC_THRESH)) u_dac_left (
        .ref_clk(ref_clk),
        .reset(reset),
        .step_en(step_en),
        .mute_bit(dac_left_mute),
        .gain_code(dac_left_gain_code),
        .reset_code(AVS_DAC_FLOOR),
        .applied_code(dac_left_applied_gain),
        .muted(dac_left_muted),
        .busy(ramp_busy[2])
    );

    // right channel has its own mute and its own ramp
    avs_ramp #(.FLOOR(AVS_DAC_FLOOR), .THRESH(AVS_DAC_THRESH)) u_dac_right (
        .ref_clk(ref_clk),
        .reset(reset),
        .step_en(step_en),
        .mute_bit(dac_right_mute),
        .gain_code(dac_right_gain_code),
        .reset_code(AVS_DAC_FLOOR),
        .applied_code(dac_right_applied_gain),
        .muted(dac_right_muted),
        .busy(ramp_busy[3])
    );

    avs_ramp #(.FLOOR(AVS_BYP_FLOOR), .THRESH(AVS_BYP_THRESH)) u_byp_left (
        .ref_clk(ref_clk),
        .reset(reset),
        .step_en(step_en),
        .mute_bit(bypass_left_mute),
        .gain_code(bypass_left_gain_code),
        .reset_code(AVS_BYP_FLOOR),
        .applied_code(bypass_left_applied_gain),
        .muted(byp_left_muted),
        .busy(ramp_busy[4])
    );

    avs_ramp #(.FLOOR(AVS_BYP_FLOOR), .THRESH(AVS_BYP_THRESH)) u_byp_right (
        .ref_clk(ref_clk),
        .reset(reset),
        .step_en(step_en),
        .mute_bit(bypass_right_mute),
        .gain_code(bypass_right_gain_code),
        .reset_code(AVS_BYP_FLOOR),
        .applied_code(bypass_right_applied_gain),
        .muted(byp_right_muted),
        .busy(ramp_busy[5])
    );

    // hard mute shorts the adc input to the common-mode reference
    assign adc_left_tie_common_mode = adc_left_muted;
    assign adc_right_tie_common_mode = adc_right_muted;

    // bypass path is cut only once its ramp has reached the floor
    assign bypass_left_path_mute = byp_left_muted;
    assign bypass_right_path_mute = byp_right_muted;

    // dac samples: zeros go to the filter while a channel is muted
    logic [AVS_SAMPLE_W-1:0] dac_left_out_r;
    logic [AVS_SAMPLE_W-1:0] dac_right_out_r;
    logic [AVS_SAMPLE_W-1:0] dac_left_sel;
    logic [AVS_SAMPLE_W-1:0] dac_right_sel;
    logic dac_out_valid_r;

    assign dac_left_sel = dac_left_muted ? '0 :
        dac_left_sample_in;
    assign dac_right_sel = dac_right_muted ? '0 :
        dac_right_sample_in;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dac_left_out_r <= '0;
            dac_right_out_r <= '0;
            dac_out_valid_r <= 1'b0;
        end else begin
            dac_out_valid_r <= dac_sample_valid;
            if (dac_sample_valid) begin
                dac_left_out_r <= dac_left_sel;
                dac_right_out_r <= dac_right_sel;
            end
        end
    end

    assign dac_left_sample_out = dac_left_out_r;
    assign dac_right_sample_out = dac_right_out_r;
    assign dac_sample_out_valid = dac_out_valid_r;

    // done flag registered so software sees a clean level
    logic done_r;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            done_r <= 1'b1;
        end else begin
            done_r <= ~(|ramp_busy);
        end
    end

    assign softstep_done_flag = done_r;

endmodule

`default_nettype wire

// [tb/avs_host_model.sv]
// host side of the register port: one write or read at a time
// assumes the block takes a strobe on the edge after it rises
`timescale 1ns/1ps
`default_nettype none

module avs_host_model
    import avs_pkg::*;
(
    input wire logic ref_clk, // clock
    output logic reg_wr_en, // write strobe
    output logic reg_rd_en, // read strobe
    output avs_addr_t reg_addr, // address
    output avs_word_t reg_wdata, // write data
    input wire avs_word_t reg_rdata, // read data
    input wire logic reg_rd_valid // read valid
);
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
    end

    task automatic wr(input avs_addr_t a, input avs_word_t d);
        @(posedge ref_clk);
        #1;
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1;
        reg_wr_en = 1'b0;
        // stale data is not left on the bus after the strobe
        reg_wdata = ~d;
    endtask

    task automatic rd(input avs_addr_t a, output avs_word_t d,
                      output logic v);
        @(posedge ref_clk);
        #1;
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(posedge ref_clk);
        #1;
        reg_rd_en = 1'b0;
        d = reg_rdata;
        v = reg_rd_valid;
    endtask
endmodule

`default_nettype wire

// [tb/avs_top_assertions.sv]
// port checks for the volume and soft-step block
// assumes it is bound onto avs_top with the same step interval
`timescale 1ns/1ps
`default_nettype none

module avs_top_checker
    import avs_pkg::*;
#(
    parameter int STEP_CYCLES = 4
) (
    input wire logic ref_clk, // clock
    input wire logic reset, // sync reset
    input wire logic reg_rd_en, // read strobe
    input wire avs_addr_t reg_addr, // address
    input wire avs_word_t reg_rdata, // read data
    input wire logic reg_rd_valid, // read valid
    input wire logic softstep_done_flag, // ramps idle
    input wire avs_code_t adc_left_applied_gain, // adc left code
    input wire logic adc_left_tie_common_mode, // adc left muted
    input wire avs_code_t dac_left_applied_gain, // dac left code
    input wire logic dac_sample_valid, // sample in
    input wire logic [AVS_SAMPLE_W-1:0] dac_left_sample_in, // left in
    input wire logic [AVS_SAMPLE_W-1:0] dac_left_sample_out, // left out
    input wire logic dac_sample_out_valid, // sample out
    input wire avs_code_t bypass_left_applied_gain, // bypass left code
    input wire logic bypass_left_path_mute // bypass left cut
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    // cycles since the adc left code last moved, saturating; settled_r
    // masks the first sample after reset, when every code jumps to floor
    logic [15:0] gap_r;
    avs_code_t prev_r;
    logic settled_r;
    always_ff @(posedge ref_clk) begin
        prev_r <= adc_left_applied_gain;
        settled_r <= ~reset;
        if (reset)
            gap_r <= 16'hFFFF;
        else if (adc_left_applied_gain != prev_r)
            gap_r <= 16'h0000;
        else if (gap_r != 16'hFFFF)
            gap_r <= gap_r + 16'h0001;
    end

    sequence byp_floor_held;
        $past(bypass_left_applied_gain) == 7'h20
            ##0 bypass_left_applied_gain == 7'h20;
    endsequence

    rd_valid_a: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read valid missing");
    unmapped_read_a: assert property (
        reg_rd_en && (reg_addr == 4'h0 || reg_addr > 4'h3)
        |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    one_unit_step_a: assert property (
        settled_r && $changed(adc_left_applied_gain) |->
        adc_left_applied_gain == $past(adc_left_applied_gain) + 7'h01 ||
        adc_left_applied_gain == $past(adc_left_applied_gain) - 7'h01)
        else $error("gain moved by more than one");
    step_spacing_a: assert property (
        settled_r && $changed(adc_left_applied_gain) |->
        int'(gap_r) >= STEP_CYCLES - 1)
        else $error("steps too close");
    tie_at_floor_a: assert property (
        adc_left_tie_common_mode |-> adc_left_applied_gain == 7'h07)
        else $error("adc tied above floor");
    ramp_busy_a: assert property (
        settled_r && $changed(adc_left_applied_gain) |-> !softstep_done_flag)
        else $error("done flag set mid ramp");
    dac_valid_a: assert property (
        dac_sample_valid |=> dac_sample_out_valid)
        else $error("sample valid missing");
    dac_pass_a: assert property (
        dac_sample_out_valid && $past(dac_left_applied_gain) != 7'h00 |->
        dac_left_sample_out == $past(dac_left_sample_in))
        else $error("live sample altered");
    bypass_mute_a: assert property (
        settled_r && $rose(bypass_left_path_mute) |-> byp_floor_held)
        else $error("bypass cut before floor");
    bypass_hold_a: assert property (
        bypass_left_path_mute |-> bypass_left_applied_gain == 7'h20)
        else $error("bypass cut above floor");
endmodule

bind avs_top avs_top_checker #(.STEP_CYCLES(STEP_CYCLES)) avs_top_checker_i (
    .ref_clk(ref_clk),
    .reset(reset),
    .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr),
    .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid),
    .softstep_done_flag(softstep_done_flag),
    .adc_left_applied_gain(adc_left_applied_gain),
    .adc_left_tie_common_mode(adc_left_tie_common_mode),
    .dac_left_applied_gain(dac_left_applied_gain),
    .dac_sample_valid(dac_sample_valid),
    .dac_left_sample_in(dac_left_sample_in),
    .dac_left_sample_out(dac_left_sample_out),
    .dac_sample_out_valid(dac_sample_out_valid),
    .bypass_left_applied_gain(bypass_left_applied_gain),
    .bypass_left_path_mute(bypass_left_path_mute)
);

`default_nettype wire

// [tb/avs_top_bench.sv]
// self-checking bench for the volume and soft-step block
// assumes a short step interval so full ramps finish quickly
`timescale 1ns/1ps
`default_nettype none

module avs_top_bench
    import avs_pkg::*;
;
    localparam int STEP = 4;
    typedef struct packed {
        avs_addr_t a;
        avs_word_t w;
        avs_word_t e;
    } avs_row_t;
    avs_row_t rows [5] = '{'{4'h1, 16'h5A3C, 16'h5A3C},
        '{4'h2, 16'h7F00, 16'h7F00}, '{4'h3, 16'h6720, 16'h6720},
        '{4'h5, 16'hFFFF, 16'h0000}, '{4'h0, 16'h1234, 16'h0000}};
    logic ref_clk, reset, wr_en, rd_en, rd_v, rate, done, sv, ov;
    logic atl, atr, bml, bmr, v;
    avs_addr_t addr;
    avs_word_t wdata, rdata, d;
    avs_code_t al, ar, dl, dr, bl, br;
    logic [19:0] sl, sr, osl, osr;
    int n_fail = 0;
    int check_count = 0;

    avs_host_model avs_host_model_i (.ref_clk(ref_clk), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata(rdata), .reg_rd_valid(rd_v));
    avs_top #(.STEP_CYCLES(STEP)) avs_top_i (.ref_clk(ref_clk),
        .reset(reset), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .reg_rd_valid(rd_v), .softstep_rate_select(rate),
        .softstep_done_flag(done), .adc_left_applied_gain(al),
        .adc_right_applied_gain(ar), .adc_left_tie_common_mode(atl),
        .adc_right_tie_common_mode(atr), .dac_left_applied_gain(dl),
        .dac_right_applied_gain(dr), .dac_sample_valid(sv),
        .dac_left_sample_in(sl), .dac_right_sample_in(sr),
        .dac_left_sample_out(osl), .dac_right_sample_out(osr),
        .dac_sample_out_valid(ov), .bypass_left_applied_gain(bl),
        .bypass_right_applied_gain(br), .bypass_left_path_mute(bml),
        .bypass_right_path_mute(bmr));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // the done flag drops one edge after the write, so wait past that first
    task automatic ramp(input avs_addr_t a, input avs_word_t w,
                        input int steps, input int per);
        int n;
        logic ok;
        avs_host_model_i.wr(a, w);
        repeat (2) @(posedge ref_clk);
        #1;
        n = 2;
        while (done !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        ok = n >= (steps - 1) * per && n <= (steps + 1) * per + 4;
        chk(20'(ok), 20'h1);
    endtask

    task automatic smp(input logic [19:0] l, input logic [19:0] el,
                       input logic [19:0] er);
        @(posedge ref_clk);
        #1;
        sv = 1'b1;
        sl = l;
        sr = ~l;
        @(posedge ref_clk);
        #1;
        sv = 1'b0;
        chk(20'(ov), 20'h1);
        chk(osl, el);
        chk(osr, er);
    endtask

    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end

    initial begin
        reset = 1'b1;
        rate = 1'b0;
        sv = 1'b0;
        sl = 20'h00000;
        sr = 20'h00000;
        repeat (3) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        foreach (rows[i]) begin
            avs_host_model_i.wr(rows[i].a, rows[i].w);
            avs_host_model_i.rd(rows[i].a, d, v);
            chk(20'(d), 20'(rows[i].e));
            chk(20'(v), 20'h1);
        end
        // second reset lands while the ramps above are still moving
        reset = 1'b1;
        @(posedge ref_clk);
        #1;
        reset = 1'b0;
        chk(20'({al, ar}), 20'({7'h07, 7'h07}));
        chk(20'({atl, atr, done}), 20'h7);
        chk(20'({dl, dr}), 20'h0);
        chk(20'({bl, br}), 20'({7'h20, 7'h20}));
        chk(20'({bml, bmr}), 20'h3);
        avs_host_model_i.rd(AVS_ADDR_ADC, d, v);
        chk(20'(d), 20'hD7D7);
        avs_host_model_i.rd(AVS_ADDR_DAC, d, v);
        chk(20'(d), 20'hFFFF);
        avs_host_model_i.rd(AVS_ADDR_BYP, d, v);
        chk(20'(d), 20'hE7E7);
        ramp(AVS_ADDR_ADC, 16'h5757, 80, STEP);
        chk(20'({al, ar}), 20'({7'h57, 7'h57}));
        chk(20'({atl, atr}), 20'h0);
        ramp(AVS_ADDR_ADC, 16'hD757, 80, STEP);
        chk(20'({al, ar}), 20'({7'h07, 7'h57}));
        chk(20'({atl, atr}), 20'h2);
        avs_host_model_i.rd(AVS_ADDR_ADC, d, v);
        chk(20'(d), 20'hD757);
        ramp(AVS_ADDR_ADC, 16'h5757, 80, STEP);
        chk(20'({al, atl}), 20'({7'h57, 1'h0}));
        ramp(AVS_ADDR_ADC, 16'h0657, 80, STEP);
        chk(20'({al, atl}), 20'({7'h07, 1'h1}));
        ramp(AVS_ADDR_ADC, 16'h7F57, 120, STEP);
        rate = 1'b1;
        ramp(AVS_ADDR_ADC, 16'h7757, 8, 2 * STEP);
        rate = 1'b0;
        ramp(AVS_ADDR_DAC, 16'h7F7F, 127, STEP);
        smp(20'h12345, 20'h12345, 20'hEDCBA);
        ramp(AVS_ADDR_DAC, 16'h7FFF, 127, STEP);
        chk(20'({dl, dr}), 20'({7'h7F, 7'h00}));
        smp(20'h5A5A5, 20'h5A5A5, 20'h00000);
        ramp(AVS_ADDR_DAC, 16'h7F7F, 127, STEP);
        chk(20'(dr), 20'h7F);
        ramp(AVS_ADDR_BYP, 16'h6767, 71, STEP);
        chk(20'({bl, bml}), 20'({7'h67, 1'h0}));
        ramp(AVS_ADDR_BYP, 16'h1F67, 71, STEP);
        chk(20'({bl, bml, bmr}), 20'({7'h20, 2'h2}));
        ramp(AVS_ADDR_BYP, 16'h67E7, 71, STEP);
        chk(20'({bl, br}), 20'({7'h67, 7'h20}));
        chk(20'({bml, bmr}), 20'h1);
        print_verdict();
    end
endmodule

`default_nettype wire
